// ==== coulomb_counter_params.svh ====
// constants for the coulomb counter core: register offsets, field positions,
// rates and timing counts; included by the core and the testbench
`ifndef COULOMB_COUNTER_PARAMS_SVH
`define COULOMB_COUNTER_PARAMS_SVH

// register byte addresses on the host register port
`define OFS_TEMP_LOW 7'h60
`define OFS_TEMP_HIGH 7'h61
`define OFS_MODE 7'h64
`define OFS_CLEAR 7'h63
`define OFS_CHG_TM_LOW 7'h65
`define OFS_CHG_TM_HIGH 7'h66
`define OFS_DIS_TM_LOW 7'h67
`define OFS_DIS_TM_HIGH 7'h68
`define OFS_SD_ACC_LOW 7'h69
`define OFS_SD_ACC_HIGH 7'h6A
`define OFS_CHG_ACC_LOW 7'h6B
`define OFS_CHG_ACC_HIGH 7'h6C
`define OFS_DIS_ACC_LOW 7'h6D
`define OFS_DIS_ACC_HIGH 7'h6E
`define OFS_VOLT_LOW 7'h71
`define OFS_VOLT_HIGH 7'h72

// mode register fields
`define MODE_POR_BIT 0
`define MODE_WAKE_LSB 1
`define MODE_SLOW_DIS_BIT 4
`define MODE_SLOW_CHG_BIT 5
`define MODE_WRITE_MASK 8'h0E

// clear register fields
`define CLEAR_DIS_ACC_BIT 0
`define CLEAR_CHG_ACC_BIT 1
`define CLEAR_SD_ACC_BIT 2
`define CLEAR_DIS_TM_BIT 3
`define CLEAR_CHG_TM_BIT 4

// timing: figures as stated, counts derived at 125 MHz
`define CLK_MHZ 125
`define TIMER_PERIOD_US 878900
`define TIMER_PERIOD_CYC (`TIMER_PERIOD_US * `CLK_MHZ)
`define SLOW_RATE_DIV 256
`define SELF_DIS_PERIOD_S 3600
`define SELF_DIS_PERIOD_CYC (64'd3600 * 64'd125000000)
`define TEMP_NOMINAL_K 298
`define TEMP_MAX_K 333
`define TEMP_MIN_K 273
`define TEMP_STEP_K 10

`endif

// ==== coulomb_counter_pkg.sv ====
// types shared by the coulomb counter core
// assumes coulomb_counter_params.svh is on the include path
package coulomb_counter_pkg;
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_SLEEP_PEND,
    ST_SLEEP,
    ST_HIBERNATE
  } power_state_t;
endpackage

// ==== coulomb_counter_core.sv ====
// accumulation and readout core of a battery monitor
// assumes a serial engine outside decodes host frames into byte reads/writes,
// and the analog front end delivers charge quanta pulses and adc words
`timescale 1ns/10ps
`default_nettype none
`include "coulomb_counter_params.svh"

// Overview of operation
// - discharge sensed: discharge count gains one per quantum, charge count idle
// - discharge timer advances 4096 counts per hour while discharging
// - charge sensed: charge count per quantum, charge timer advances
// - both timers are 16-bit and wrap past ffff to zero
// - timer wrap sets its slow flag; then counts at 1/256 rate
// - timer period 0.8789 s normally, 225 s with slow flag
// - self-discharge count 16 bits, one per hour at 25 C
// - above 25 C rate doubles each 10 C up to 60 C
// - below 25 C rate halves each 10 C down to 0 C
// - after sleep command and low activity, stop all but self-discharge
// - 3-bit wake threshold: 0 none, 1..7 decreasing thresholds
// - asleep, self-discharge count keeps updating without leaving sleep
// - any edge on host line ends sleep
// - normal: all counters; sleep: self-discharge only; hibernate: none
// - power-on-reset indication enters hibernate, held until removed
// - sense offset compensated continuously without host action
// - writing one to clear bit zeros counter; bit self-clears after
// - clearing either timer clears both slow flags
// - die temperature in kelvin readable as high/low pair
// - voltage 11 bits, msb in high bit 2, lsb in low bit 0
// - high bits 7..3 hold signed-magnitude adc offset
module coulomb_counter_core
  import coulomb_counter_pkg::*;
#(
  parameter longint unsigned TIMER_PERIOD_CYC = `TIMER_PERIOD_CYC,
  parameter longint unsigned SELF_DIS_PERIOD_CYC = `SELF_DIS_PERIOD_CYC,
  parameter int OFFSET_FILTER_SHIFT = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chg_quantum,
  input wire logic dis_quantum,
  input wire logic [4:0] activity_level,
  input wire logic sense_shorted,
  input wire logic single_wire_host_line,
  input wire logic por_indication,
  input wire logic sleep_cmd,
  input wire logic [10:0] battery_adc_code,
  input wire logic [4:0] battery_adc_offset,
  input wire logic [10:0] die_temp_kelvin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [1:0] power_state,
  output logic acq_clock_on
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [1:0] chg_s_r, dis_s_r, line_s_r, por_s_r, short_s_r;
  logic chg_q_r, dis_q_r, line_d_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_s_r <= 2'h0;
      dis_s_r <= 2'h0;
      line_s_r <= 2'h3;
      por_s_r <= 2'h3;
      short_s_r <= 2'h0;
    end else begin
      chg_s_r <= {chg_s_r[0], chg_quantum};
      dis_s_r <= {dis_s_r[0], dis_quantum};
      line_s_r <= {line_s_r[0], single_wire_host_line};
      por_s_r <= {por_s_r[0], por_indication};
      short_s_r <= {short_s_r[0], sense_shorted};
    end
  end

  // edge detect on synchronised pulses (slow front-end toggles assumed)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_q_r <= 1'b0;
      dis_q_r <= 1'b0;
      line_d_r <= 1'b1;
    end else begin
      chg_q_r <= chg_s_r[1];
      dis_q_r <= dis_s_r[1];
      line_d_r <= line_s_r[1];
    end
  end
  logic chg_evt, dis_evt, line_edge;
  assign chg_evt = chg_s_r[1] & ~chg_q_r;
  assign dis_evt = dis_s_r[1] & ~dis_q_r;
  assign line_edge = line_s_r[1] ^ line_d_r;

  // ------------------------------------------------------------
  // registers and power state
  // ------------------------------------------------------------
  logic [15:0] chg_acc_r, dis_acc_r, sd_acc_r, chg_tm_r, dis_tm_r;
  logic slow_chg_r, slow_dis_r;
  logic [2:0] wake_sel_r;
  logic [4:0] clr_r;
  power_state_t state_r;
  logic run_all, run_self;
  assign run_all = (state_r == ST_NORMAL) || (state_r == ST_SLEEP_PEND);
  assign run_self = state_r != ST_HIBERNATE;
  assign power_state = state_r;
  assign acq_clock_on = run_all;

  // threshold table in quarter-code units of activity_level
  function automatic logic below_wake(input logic [2:0] sel, input logic [4:0] lvl);
    logic [4:0] lim;
    lim = 5'h00;
    unique case (sel)
      3'h0: lim = 5'h1F;
      3'h1: lim = 5'h1C;
      3'h2: lim = 5'h0E;
      3'h3: lim = 5'h09;
      3'h4: lim = 5'h07;
      3'h5: lim = 5'h05;
      3'h6: lim = 5'h04;
      3'h7: lim = 5'h03;
    endcase
    below_wake = (sel == 3'h0) || (lvl < lim);
  endfunction

  // power state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_HIBERNATE;
    end else if (por_s_r[1]) begin
      state_r <= ST_HIBERNATE;
    end else begin
      unique case (state_r)
        ST_HIBERNATE: state_r <= ST_NORMAL;
        ST_NORMAL: if (sleep_cmd) state_r <= ST_SLEEP_PEND;
        ST_SLEEP_PEND: begin
          if (line_edge) state_r <= ST_NORMAL;
          else if (below_wake(wake_sel_r, activity_level)) state_r <= ST_SLEEP;
        end
        ST_SLEEP: if (line_edge) state_r <= ST_NORMAL;
      endcase
    end
  end

  // ------------------------------------------------------------
  // offset compensation: a shorted-input reference count is removed
  // ------------------------------------------------------------
  logic [OFFSET_FILTER_SHIFT-1:0] offs_acc_r;
  logic offs_skip_chg_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      offs_acc_r <= '0;
      offs_skip_chg_r <= 1'b0;
    end else if (short_s_r[1]) begin
      // quanta during the short are offset, remembered for cancellation
      if (chg_evt) offs_skip_chg_r <= 1'b1;
      if (dis_evt) offs_skip_chg_r <= 1'b0;
      if (chg_evt | dis_evt) offs_acc_r <= offs_acc_r + 1'b1;
    end else if ((chg_evt & offs_skip_chg_r) | (dis_evt & ~offs_skip_chg_r)) begin
      if (offs_acc_r != '0) offs_acc_r <= offs_acc_r - 1'b1;
    end
  end
  logic offs_eat;
  assign offs_eat = offs_acc_r != '0;
  logic chg_cnt, dis_cnt;
  assign chg_cnt = chg_evt & ~short_s_r[1] & ~(offs_eat & offs_skip_chg_r);
  assign dis_cnt = dis_evt & ~short_s_r[1] & ~(offs_eat & ~offs_skip_chg_r);

  // direction holds until the opposite quantum arrives
  logic charging_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) charging_r <= 1'b0;
    else if (chg_evt) charging_r <= 1'b1;
    else if (dis_evt) charging_r <= 1'b0;
  end

  // ------------------------------------------------------------
  // charge and discharge count
  // ------------------------------------------------------------
  // discharge count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) dis_acc_r <= 16'h0000;
    else if (clr_r[`CLEAR_DIS_ACC_BIT]) dis_acc_r <= 16'h0000;
    else if (run_all && dis_cnt) dis_acc_r <= dis_acc_r + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) chg_acc_r <= 16'h0000;
    else if (clr_r[`CLEAR_CHG_ACC_BIT]) chg_acc_r <= 16'h0000;
    else if (run_all && chg_cnt) chg_acc_r <= chg_acc_r + 16'h0001;
  end

  // ------------------------------------------------------------
  // time counters
  // ------------------------------------------------------------
  logic [63:0] tick_cnt_r;
  logic tick;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) tick_cnt_r <= 64'h0000_0000_0000_0000;
    else if (!run_all || tick) tick_cnt_r <= 64'h0000_0000_0000_0000;
    else tick_cnt_r <= tick_cnt_r + 64'h0000_0000_0000_0001;
  end
  assign tick = run_all && (tick_cnt_r == TIMER_PERIOD_CYC - 1);

  logic [7:0] pre_chg_r, pre_dis_r;
  logic timer_clr;
  assign timer_clr = clr_r[`CLEAR_CHG_TM_BIT] | clr_r[`CLEAR_DIS_TM_BIT];
  logic chg_tm_step, dis_tm_step;
  assign chg_tm_step = tick && charging_r && (!slow_chg_r || pre_chg_r == 8'hFF);
  assign dis_tm_step = tick && !charging_r && (!slow_dis_r || pre_dis_r == 8'hFF);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_chg_r <= 8'h00;
      pre_dis_r <= 8'h00;
    end else if (timer_clr) begin
      pre_chg_r <= 8'h00;
      pre_dis_r <= 8'h00;
    end else begin
      if (tick && charging_r && slow_chg_r) pre_chg_r <= pre_chg_r + 8'h01;
      if (tick && !charging_r && slow_dis_r) pre_dis_r <= pre_dis_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) dis_tm_r <= 16'h0000;
    else if (clr_r[`CLEAR_DIS_TM_BIT]) dis_tm_r <= 16'h0000;
    else if (dis_tm_step) dis_tm_r <= dis_tm_r + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) chg_tm_r <= 16'h0000;
    else if (clr_r[`CLEAR_CHG_TM_BIT]) chg_tm_r <= 16'h0000;
    else if (chg_tm_step) chg_tm_r <= chg_tm_r + 16'h0001;
  end

  // slow flags set on wrap; set wins over a clear in the same cycle
  // timer clear drops flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_chg_r <= 1'b0;
      slow_dis_r <= 1'b0;
    end else begin
      if (chg_tm_step && chg_tm_r == 16'hFFFF) slow_chg_r <= 1'b1;
      else if (timer_clr) slow_chg_r <= 1'b0;
      if (dis_tm_step && dis_tm_r == 16'hFFFF) slow_dis_r <= 1'b1;
      else if (timer_clr) slow_dis_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // self-discharge count, temperature scaled
  // ------------------------------------------------------------
  // rate exponent: +1 per 10 K above 298 to 333, -1 per 10 K below to 273
  function automatic logic signed [3:0] temp_exp(input logic [10:0] tk);
    int t;
    t = int'(tk);
    if (t > `TEMP_MAX_K) t = `TEMP_MAX_K;
    if (t < `TEMP_MIN_K) t = `TEMP_MIN_K;
    if (t >= `TEMP_NOMINAL_K) temp_exp = 4'((t - `TEMP_NOMINAL_K) / `TEMP_STEP_K);
    else temp_exp = -4'((`TEMP_NOMINAL_K - t + `TEMP_STEP_K - 1) / `TEMP_STEP_K);
  endfunction

  logic signed [3:0] sd_exp;
  logic [63:0] sd_limit;
  assign sd_exp = temp_exp(die_temp_kelvin);
  assign sd_limit = (sd_exp >= 0) ? (SELF_DIS_PERIOD_CYC >> sd_exp) : (SELF_DIS_PERIOD_CYC << (-sd_exp));

  logic [63:0] sd_cnt_r;
  logic sd_tick;
  assign sd_tick = run_self && (sd_cnt_r + 64'h0000_0000_0000_0001 >= sd_limit);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sd_cnt_r <= 64'h0000_0000_0000_0000;
    else if (sd_tick) sd_cnt_r <= 64'h0000_0000_0000_0000;
    else if (run_self) sd_cnt_r <= sd_cnt_r + 64'h0000_0000_0000_0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sd_acc_r <= 16'h0000;
    else if (clr_r[`CLEAR_SD_ACC_BIT]) sd_acc_r <= 16'h0000;
    else if (sd_tick) sd_acc_r <= sd_acc_r + 16'h0001;
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  // clear register self-clears after one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) clr_r <= 5'h00;
    else if (reg_wr && reg_addr == `OFS_CLEAR && !clr_r[0] && clr_r == 5'h00) clr_r <= reg_wdata[4:0];
    else clr_r <= 5'h00;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wake_sel_r <= 3'h0;
    else if (reg_wr && reg_addr == `OFS_MODE) wake_sel_r <= reg_wdata[`MODE_WAKE_LSB +: 3];
  end

  logic [7:0] mode_val;
  assign mode_val = {2'b00, slow_chg_r, slow_dis_r, wake_sel_r, por_s_r[1]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_TEMP_LOW: reg_rdata <= die_temp_kelvin[7:0];
        `OFS_TEMP_HIGH: reg_rdata <= {5'b00000, die_temp_kelvin[10:8]};
        `OFS_CLEAR: reg_rdata <= {3'b000, clr_r};
        `OFS_MODE: reg_rdata <= mode_val;
        `OFS_CHG_TM_LOW: reg_rdata <= chg_tm_r[7:0];
        `OFS_CHG_TM_HIGH: reg_rdata <= chg_tm_r[15:8];
        `OFS_DIS_TM_LOW: reg_rdata <= dis_tm_r[7:0];
        `OFS_DIS_TM_HIGH: reg_rdata <= dis_tm_r[15:8];
        `OFS_SD_ACC_LOW: reg_rdata <= sd_acc_r[7:0];
        `OFS_SD_ACC_HIGH: reg_rdata <= sd_acc_r[15:8];
        `OFS_CHG_ACC_LOW: reg_rdata <= chg_acc_r[7:0];
        `OFS_CHG_ACC_HIGH: reg_rdata <= chg_acc_r[15:8];
        `OFS_DIS_ACC_LOW: reg_rdata <= dis_acc_r[7:0];
        `OFS_DIS_ACC_HIGH: reg_rdata <= dis_acc_r[15:8];
        `OFS_VOLT_LOW: reg_rdata <= battery_adc_code[7:0];
        `OFS_VOLT_HIGH: reg_rdata <= {battery_adc_offset, battery_adc_code[10:8]};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_DIS_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    run_all && dis_cnt && !clr_r[0] |=> dis_acc_r == $past(dis_acc_r) + 16'h0001)
    else $error("discharge count missed");
  AST_CHG_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !chg_evt && !clr_r[1] |=> chg_acc_r == $past(chg_acc_r))
    else $error("charge count moved without quantum");
  AST_WRAP_SLOW: assert property (@(posedge clk) disable iff (!rst_b)
    dis_tm_step && dis_tm_r == 16'hFFFF |=> slow_dis_r && dis_tm_r == 16'h0000)
    else $error("timer wrap without slow flag");
  AST_CLR_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
    timer_clr && !chg_tm_step && !dis_tm_step |=> !slow_chg_r && !slow_dis_r)
    else $error("timer clear kept slow flags");
  AST_CLR_SELF: assert property (@(posedge clk) disable iff (!rst_b)
    clr_r != 5'h00 |=> clr_r == 5'h00)
    else $error("clear bit did not return to zero");
  AST_HIB_FROZEN: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_HIBERNATE |=> $stable(sd_acc_r) && $stable(chg_acc_r))
    else $error("counter moved in hibernate");
  AST_POR_HIB: assert property (@(posedge clk) disable iff (!rst_b)
    por_s_r[1] |=> state_r == ST_HIBERNATE)
    else $error("por did not hibernate");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_SLEEP && line_edge && !por_s_r[1] |=> state_r == ST_NORMAL)
    else $error("line edge did not wake");
  AST_SLEEP_FROZEN: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_SLEEP |=> $stable(dis_tm_r) && $stable(dis_acc_r))
    else $error("acquisition ran in sleep");
  COV_SLEEP: cover property (@(posedge clk) state_r == ST_SLEEP_PEND ##1 state_r == ST_SLEEP);
  COV_WRAP: cover property (@(posedge clk) chg_tm_step && chg_tm_r == 16'hFFFF);
  COV_CLEAR: cover property (@(posedge clk) clr_r[`CLEAR_DIS_TM_BIT]);

endmodule
`default_nettype wire

// ==== coulomb_host_model.sv ====
// host controller model: register port strobes, sleep request, host line
// assumes the core samples strobes on the rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module coulomb_host_model #(
  parameter logic [6:0] FLASH_CMD_ADDR = 7'h62,
  parameter logic [7:0] SAVE_CMD = 8'h01
) (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic sleep_cmd,
  output logic single_wire_host_line
);
  // -----------------------------------------
  // idle levels
  // -----------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    sleep_cmd = 1'b0;
    single_wire_host_line = 1'b1;
  end

  // one write; keep leaves the strobe up for a back-to-back write
  // released fields show the inverse so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input bit keep);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    if (!keep) begin
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask

  // one read; data is taken a cycle after the strobe edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  task automatic go_sleep();
    wr(FLASH_CMD_ADDR, SAVE_CMD, 1'b0);
    @(negedge clk);
    sleep_cmd = 1'b1;
    @(negedge clk);
    sleep_cmd = 1'b0;
  endtask

  // either edge on the line ends sleep; alternates rising and falling
  task automatic toggle_line();
    @(negedge clk);
    single_wire_host_line = ~single_wire_host_line;
  endtask

  // host applies gain and offset itself, result in microvolts
  function automatic int corrected_uv(input int raw, input int gain_uv, input int off_uv);
    return raw * (2440 + gain_uv) - off_uv;
  endfunction
endmodule
`default_nettype wire

// ==== tb_coulomb_counter_core.sv ====
// self-checking bench for the coulomb counter core
// assumes the params header on the include path; short timer periods
`timescale 1ns/10ps
`default_nettype none
`include "coulomb_counter_params.svh"
module tb_coulomb_counter_core;
  import coulomb_counter_pkg::*;
  logic clk, rst_b, chg_quantum, dis_quantum, sense_shorted, por_indication;
  logic sleep_cmd, single_wire_host_line, reg_wr, reg_rd, acq_clock_on;
  logic [4:0] activity_level, battery_adc_offset;
  logic [10:0] battery_adc_code, die_temp_kelvin;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, b;
  logic [1:0] power_state;
  logic [15:0] v, w;
  int num_errors, compares;
  logic [4:0] thr [8] = '{5'h00, 5'h1C, 5'h0E, 5'h09, 5'h07, 5'h05, 5'h04, 5'h03};
  int temps [3] = '{298, 308, 288};
  int sd_exp [3] = '{20, 40, 10};

  coulomb_counter_core #(.TIMER_PERIOD_CYC(1), .SELF_DIS_PERIOD_CYC(64)) i_coulomb_counter_core (
    .clk(clk), .rst_b(rst_b), .chg_quantum(chg_quantum), .dis_quantum(dis_quantum),
    .activity_level(activity_level), .sense_shorted(sense_shorted),
    .single_wire_host_line(single_wire_host_line), .por_indication(por_indication),
    .sleep_cmd(sleep_cmd), .battery_adc_code(battery_adc_code),
    .battery_adc_offset(battery_adc_offset), .die_temp_kelvin(die_temp_kelvin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_state(power_state), .acq_clock_on(acq_clock_on));

  coulomb_host_model i_coulomb_host_model (
    .clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .sleep_cmd(sleep_cmd), .single_wire_host_line(single_wire_host_line));

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // run needs about 72k cycles; cut off at 90k so a hang stays bounded
  initial begin
    #720000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic inrange(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
    check({15'h0, (x >= lo) && (x <= hi)}, 16'h0001);
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // low byte at the lower address, no latching of the high byte
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    i_coulomb_host_model.rd(a, d[7:0]);
    i_coulomb_host_model.rd(7'(a + 7'd1), d[15:8]);
  endtask

  task automatic clr(input logic [7:0] m);
    i_coulomb_host_model.wr(`OFS_CLEAR, m, 1'b0);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // pulses wide enough for the front-end synchroniser, then let them land
  task automatic quanta(input bit chg, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      chg_quantum = chg;
      dis_quantum = !chg;
      cycles(4);
      chg_quantum = 1'b0;
      dis_quantum = 1'b0;
      cycles(4);
    end
    cycles(8);
  endtask

  task automatic wait_state(input logic [1:0] s);
    for (int i = 0; i < 40 && power_state !== s; i++) begin
      @(negedge clk);
    end
    check({14'h0, power_state}, {14'h0, s});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    num_errors = 0;
    compares = 0;
    rst_b = 1'b0;
    chg_quantum = 1'b0;
    dis_quantum = 1'b0;
    sense_shorted = 1'b0;
    por_indication = 1'b0;
    activity_level = 5'h00;
    battery_adc_code = 11'h5A3;
    battery_adc_offset = 5'h15;
    die_temp_kelvin = 11'd298;
    cycles(5);
    rst_b = 1'b1;
    cycles(3);
    wait_state(2'd0);
    check({15'h0, acq_clock_on}, 16'h0001);
    rd16(`OFS_DIS_ACC_LOW, v);
    check(v, 16'h0000);
    i_coulomb_host_model.rd(7'h73, b);
    check({8'h0, b}, 16'h0000);
    i_coulomb_host_model.rd(`OFS_TEMP_LOW, b);
    check({8'h0, b}, 16'h002A);
    i_coulomb_host_model.rd(`OFS_TEMP_HIGH, b);
    check({8'h0, b}, 16'h0001);
    i_coulomb_host_model.rd(`OFS_VOLT_LOW, b);
    check({8'h0, b}, 16'h00A3);
    i_coulomb_host_model.rd(`OFS_VOLT_HIGH, b);
    check({8'h0, b}, 16'h00AD);
    check(16'(i_coulomb_host_model.corrected_uv(10, 10, 4000)), 16'h5014);
    // discharge then charge quanta
    quanta(1'b0, 5);
    rd16(`OFS_DIS_ACC_LOW, v);
    check(v, 16'h0005);
    quanta(1'b1, 4);
    rd16(`OFS_CHG_ACC_LOW, v);
    check(v, 16'h0004);
    rd16(`OFS_DIS_ACC_LOW, v);
    check(v, 16'h0005);
    // timers follow the sensed direction
    clr(8'h18);
    cycles(40);
    rd16(`OFS_DIS_TM_LOW, v);
    check(v, 16'h0000);
    rd16(`OFS_CHG_TM_LOW, v);
    inrange(v, 16'd30, 16'd70);
    quanta(1'b0, 1);
    clr(8'h18);
    cycles(40);
    rd16(`OFS_CHG_TM_LOW, v);
    check(v, 16'h0000);
    rd16(`OFS_DIS_TM_LOW, v);
    inrange(v, 16'd30, 16'd70);
    // back-to-back clear: second write is refused while the first completes
    i_coulomb_host_model.wr(`OFS_CLEAR, 8'h01, 1'b1);
    i_coulomb_host_model.wr(`OFS_CLEAR, 8'h02, 1'b0);
    i_coulomb_host_model.rd(`OFS_CLEAR, b);
    check({8'h0, b}, 16'h0000);
    rd16(`OFS_DIS_ACC_LOW, v);
    check(v, 16'h0000);
    rd16(`OFS_CHG_ACC_LOW, v);
    check(v, 16'h0004);
    // a spaced clear of the charge count does land
    clr(8'h02);
    rd16(`OFS_CHG_ACC_LOW, v);
    check(v, 16'h0000);
    // quanta under shorted inputs cancel later ones
    sense_shorted = 1'b1;
    quanta(1'b0, 2);
    sense_shorted = 1'b0;
    quanta(1'b0, 5);
    rd16(`OFS_DIS_ACC_LOW, v);
    check(v, 16'h0003);
    // self-discharge rate against temperature
    for (int t = 0; t < 3; t++) begin
      die_temp_kelvin = 11'(temps[t]);
      clr(8'h04);
      cycles(1280);
      rd16(`OFS_SD_ACC_LOW, v);
      inrange(v, 16'(sd_exp[t] - 1), 16'(sd_exp[t] + 1));
    end
    die_temp_kelvin = 11'd298;
    // sleep entry for every wake threshold code, wake by either edge
    for (int s = 0; s < 8; s++) begin
      i_coulomb_host_model.wr(`OFS_MODE, {4'h0, 3'(s), 1'b0}, 1'b0);
      activity_level = thr[s];
      rd16(`OFS_SD_ACC_LOW, v);
      i_coulomb_host_model.go_sleep();
      if (s != 0) begin
        wait_state(2'd1);
        activity_level = thr[s] - 5'd1;
      end
      wait_state(2'd2);
      check({15'h0, acq_clock_on}, 16'h0000);
      if (s == 0) begin
        quanta(1'b0, 3);
        cycles(640);
      end
      i_coulomb_host_model.toggle_line();
      wait_state(2'd0);
      if (s == 0) begin
        rd16(`OFS_SD_ACC_LOW, w);
        inrange(w - v, 16'd9, 16'd14);
        rd16(`OFS_DIS_ACC_LOW, w);
        check(w, 16'h0003);
      end
    end
    // hibernate freezes every counter
    rd16(`OFS_SD_ACC_LOW, v);
    por_indication = 1'b1;
    wait_state(2'd3);
    check({15'h0, acq_clock_on}, 16'h0000);
    quanta(1'b0, 2);
    cycles(300);
    por_indication = 1'b0;
    wait_state(2'd0);
    rd16(`OFS_SD_ACC_LOW, w);
    inrange(w - v, 16'd0, 16'd1);
    rd16(`OFS_DIS_ACC_LOW, w);
    check(w, 16'h0003);
    // discharge timer wrap and slow rate
    quanta(1'b0, 1);
    clr(8'h08);
    cycles(65536 + 50);
    i_coulomb_host_model.rd(`OFS_MODE, b);
    check({14'h0, b[5:4]}, 16'h0001);
    rd16(`OFS_DIS_TM_LOW, v);
    inrange(v, 16'd0, 16'd1);
    cycles(1024);
    rd16(`OFS_DIS_TM_LOW, w);
    inrange(w - v, 16'd3, 16'd5);
    // clearing the other timer restores the default rate
    clr(8'h10);
    i_coulomb_host_model.rd(`OFS_MODE, b);
    check({14'h0, b[5:4]}, 16'h0000);
    rd16(`OFS_DIS_TM_LOW, v);
    cycles(100);
    rd16(`OFS_DIS_TM_LOW, w);
    inrange(w - v, 16'd95, 16'd120);
    give_verdict();
  end
endmodule
`default_nettype wire
